/* File: hw/dps_cfg.svh */
// constants for the debug port select and enable block
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// system clock period in ns
`define DPS_CLK_PERIOD_NS 100
// post-reset key window in ns, longest time so it rounds down
`define DPS_KEY_WINDOW_NS 8000
`define DPS_KEY_WINDOW_CYC (`DPS_KEY_WINDOW_NS / `DPS_CLK_PERIOD_NS)
// width of the key window counter
`define DPS_WIN_W 8
// boot count, reached after reset release, at which the lock strap is taken
`define DPS_BOOT_CYC 2'h3
// key sequence length and value (value is arbitrary)
`define DPS_KEY_LEN 8
`define DPS_SWD_KEY 8'hB4
// width of the key bit counter
`define DPS_KCNT_W 5
// reset values of the control flags
`define DPS_RST_DEBUG 1'h0
`define DPS_RST_BLOCKED 1'h0
`define DPS_RST_REEN 1'h0
// claim mask bit positions
`define DPS_PIN_TCK 0
`define DPS_PIN_TMS 1
`define DPS_PIN_TDI 2
`define DPS_PIN_TDO 3
`define DPS_PIN_TRST 4
`define DPS_PIN_USB_DP 5
`define DPS_PIN_USB_DM 6
`define DPS_PIN_N 7

`endif

/* File: hw/dps_pkg.sv */
// types for the debug port select and enable block
package dps_pkg;

  // acquisition state of the debug ports
  typedef enum logic [2:0] {
    st_boot,
    st_window,
    st_idle,
    st_swd_scan,
    st_swd_usb,
    st_locked
  } dps_state_t;

  // candidate pin pair for the two-wire port
  typedef enum logic {
    pair_scan,
    pair_usb
  } dps_pair_t;

endpackage

/* File: hw/dps_key_detect.sv */
// key sequence detector for one candidate pin pair
`timescale 1ns/1ps
`include "dps_cfg.svh"

module dps_key_detect
  import dps_pkg::*;
#(
  parameter int                  KEY_LEN = `DPS_KEY_LEN,
  parameter logic [KEY_LEN-1:0]  KEY     = `DPS_SWD_KEY
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic open_win,
  input  wire logic clk_s,
  input  wire logic data_s,
  output logic      hit
);

  logic                   clk_prev;
  logic [KEY_LEN-1:0]     shreg;
  logic [`DPS_KCNT_W-1:0] nbits;
  logic                   rise;
  logic                   full;
  logic [KEY_LEN-1:0]     next_shreg;

  // a link clock edge is seen only while the link stays below
  // half the system clock
  assign rise       = clk_s & ~clk_prev;
  assign full       = (nbits >= `DPS_KCNT_W'(KEY_LEN));
  assign next_shreg = {shreg[KEY_LEN-2:0], data_s};

  // shift one data bit on each rising link clock edge while the window is open
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev <= 1'h0;
      shreg    <= '0;
      nbits    <= '0;
    end else begin
      clk_prev <= clk_s;
      if (open_win && rise) begin
        shreg <= next_shreg;
        if (!full) begin
          nbits <= nbits + `DPS_KCNT_W'(1);
        end
      end
    end
  end

  // match once a whole key has been shifted in during the window
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hit <= 1'h0;
    end else begin
      hit <= open_win && full && (shreg == KEY);
    end
  end

endmodule // dps_key_detect

/* File: hw/dps_port_select.sv */
// pin ownership and enables for the scan and two-wire debug ports
`timescale 1ns/1ps
`include "dps_cfg.svh"

// Overview of operation
// - debug off at reset, firmware alone enables
// - unenabled debug returns only after erase, reprogram; here a reset also clears the block
// - security lock shuts every port for good
// - claim 0, 4/5, 2, 3 or 6/7 pins (scan port plus usb pair)
// - scan port on four or five pins
// - scan port on by default, option disables
// - two-wire port debugs, no chain access
// - two-wire on scan pair or usb pair
// - key within window picks exactly one pair
// - scan path enables two-wire, or disable it
// - key window always reacquires, may reenable scan
// - scan port gives chains and device chaining
// - trace out on data-out, two-wire only
module dps_port_select
  import dps_pkg::*;
#(
  parameter bit                   HAS_TRST = 1'b1,
  parameter int                   KEY_LEN  = `DPS_KEY_LEN,
  parameter logic [KEY_LEN-1:0]   KEY      = `DPS_SWD_KEY
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic security_lock,
  input  wire logic cfg_scan_disable,
  input  wire logic cfg_swd_via_scan,
  input  wire logic cfg_swd_disable,
  input  wire logic fw_debug_set,
  input  wire logic fw_boot_done,
  input  wire logic chip_erase_done,
  input  wire logic flash_prot_clear,
  input  wire logic swd_scan_reenable,
  input  wire logic trace_req,
  input  wire logic trace_bit,
  input  wire logic scan_tdo,
  input  wire logic swd_dio_out,
  input  wire logic swd_dio_oe,
  input  wire logic tck_in,
  input  wire logic tms_in,
  input  wire logic tdi_in,
  input  wire logic trst_n_in,
  input  wire logic usb_dp_in,
  input  wire logic usb_dm_in,
  output logic      tms_out,
  output logic      tms_oe,
  output logic      tdo_out,
  output logic      tdo_oe,
  output logic      usb_dp_out,
  output logic      usb_dp_oe,
  output logic      scan_en,
  output logic      scan_tck,
  output logic      scan_tms,
  output logic      scan_tdi,
  output logic      scan_trst_n,
  output logic      chain_access_en,
  output logic      swd_en,
  output logic      swd_on_usb,
  output logic      swd_clk,
  output logic      swd_dio_in,
  output logic      trace_en,
  output logic      on_chip_debug,
  output logic      dbg_circuit_en,
  output logic      dbg_blocked,
  output logic      usb_io_pins_claimed,
  output logic [2:0] pins_claimed
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  localparam int SYN_N = 10;

  logic [SYN_N-1:0] sync1;
  logic [SYN_N-1:0] sync2;
  logic             s_lock;
  logic             s_scan_dis;
  logic             s_swd_via;
  logic             s_swd_dis;
  logic             s_tck;
  logic             s_tms;
  logic             s_tdi;
  logic             s_trst_n;
  logic             s_usb_dp;
  logic             s_usb_dm;

  // two flops on every pin and strap; only sync2 is read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {security_lock, cfg_scan_disable, cfg_swd_via_scan,
                cfg_swd_disable, tck_in, tms_in, tdi_in, trst_n_in,
                usb_dp_in, usb_dm_in};
      sync2 <= sync1;
    end
  end

  assign {s_lock, s_scan_dis, s_swd_via, s_swd_dis, s_tck, s_tms, s_tdi,
          s_trst_n, s_usb_dp, s_usb_dm} = sync2;

  ////////////////////////////////////////////////////////////////////////
  // key detection on both candidate pairs

  dps_state_t            state;
  dps_state_t            next_state;
  logic [1:0]            boot_cnt;
  logic [`DPS_WIN_W-1:0] win_cnt;
  logic                  win_open;
  logic                  win_last;
  logic                  hit_scan;
  logic                  hit_usb;

  assign win_open = (state == st_window);
  assign win_last = (win_cnt == `DPS_WIN_W'(`DPS_KEY_WINDOW_CYC - 1));

  // scan pair: clock on scan clock, data on mode select
  dps_key_detect #(
    .KEY_LEN (KEY_LEN),
    .KEY     (KEY)
  ) u_key_scan (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .open_win (win_open),
    .clk_s    (s_tck),
    .data_s   (s_tms),
    .hit      (hit_scan)
  );

  // usb pair: clock on D-, data on D+
  dps_key_detect #(
    .KEY_LEN (KEY_LEN),
    .KEY     (KEY)
  ) u_key_usb (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .open_win (win_open),
    .clk_s    (s_usb_dm),
    .data_s   (s_usb_dp),
    .hit      (hit_usb)
  );

  ////////////////////////////////////////////////////////////////////////
  // acquisition state machine

  // boot waits for the strap, window then picks at most one pair
  always_comb begin
    next_state = state;
    case (state)
      st_boot: begin
        if (boot_cnt == `DPS_BOOT_CYC) begin
          next_state = s_lock ? st_locked : st_window;
        end
      end
      st_window: begin
        if (hit_scan) begin
          next_state = st_swd_scan;
        end else if (hit_usb) begin
          next_state = st_swd_usb;
        end else if (win_last) begin
          next_state = st_idle;
        end
      end
      default: next_state = state;
    endcase
  end

  // state, boot delay and window counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= st_boot;
      boot_cnt <= 2'h0;
      win_cnt  <= '0;
    end else begin
      state <= next_state;
      if (state == st_boot) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
      if (win_open) begin
        win_cnt <= win_cnt + `DPS_WIN_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debug enable flags

  logic scan_reen;

  // firmware alone sets debug; a boot without it blocks until reset or until erase with flash protection cleared
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_chip_debug <= `DPS_RST_DEBUG;
      dbg_blocked   <= `DPS_RST_BLOCKED;
    end else begin
      if (fw_debug_set && !dbg_blocked && state != st_locked) begin
        on_chip_debug <= 1'h1;
      end
      if (fw_boot_done && !on_chip_debug) begin
        dbg_blocked <= 1'h1;
      end else if (chip_erase_done && flash_prot_clear) begin
        dbg_blocked <= 1'h0;
      end
    end
  end

  // an acquired two-wire port may hand the scan pins back
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_reen <= `DPS_RST_REEN;
    end else if (swd_scan_reenable &&
                 (state == st_swd_scan || state == st_swd_usb)) begin
      scan_reen <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin ownership decode

  logic                  live;
  logic                  swd_scan_w;
  logic                  swd_usb_w;
  logic                  scan_en_w;
  logic                  trace_w;
  logic [`DPS_PIN_N-1:0] claim_w;

  // count of claimed pins
  function automatic logic [2:0] claim_count(
    input logic [`DPS_PIN_N-1:0] m
  );
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `DPS_PIN_N; i++) begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction

  assign live       = (state != st_boot) && (state != st_locked);
  // key or scan-side config puts the two-wire port on scan pins
  assign swd_scan_w = live && !scan_reen && ((state == st_swd_scan) ||
                      (state == st_idle && s_swd_via && !s_swd_dis));
  assign swd_usb_w  = live && (state == st_swd_usb);
  // scan port on by default unless the option clears it
  assign scan_en_w  = live && !swd_scan_w && (!s_scan_dis || scan_reen);
  assign trace_w    = trace_req && (swd_scan_w || swd_usb_w) &&
                      !scan_en_w;
  assign claim_w[`DPS_PIN_TCK]    = scan_en_w || swd_scan_w;
  assign claim_w[`DPS_PIN_TMS]    = scan_en_w || swd_scan_w;
  assign claim_w[`DPS_PIN_TDI]    = scan_en_w;
  assign claim_w[`DPS_PIN_TDO]    = scan_en_w || trace_w;
  assign claim_w[`DPS_PIN_TRST]   = scan_en_w && HAS_TRST;
  assign claim_w[`DPS_PIN_USB_DP] = swd_usb_w;
  assign claim_w[`DPS_PIN_USB_DM] = swd_usb_w;

  ////////////////////////////////////////////////////////////////////////
  // registered enables and routing

  // enables and claim count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_en             <= 1'h0;
      chain_access_en     <= 1'h0;
      swd_en              <= 1'h0;
      swd_on_usb          <= 1'h0;
      trace_en            <= 1'h0;
      dbg_circuit_en      <= 1'h0;
      usb_io_pins_claimed <= 1'h0;
      pins_claimed        <= 3'h0;
    end else begin
      scan_en             <= scan_en_w;
      chain_access_en     <= scan_en_w;
      swd_en              <= swd_scan_w || swd_usb_w;
      swd_on_usb          <= swd_usb_w;
      trace_en            <= trace_w;
      dbg_circuit_en      <= on_chip_debug && live;
      usb_io_pins_claimed <= swd_usb_w;
      pins_claimed        <= claim_count(claim_w);
    end
  end

  // scan port signals to the test access logic
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_tck    <= 1'h0;
      scan_tms    <= 1'h0;
      scan_tdi    <= 1'h0;
      scan_trst_n <= 1'h0;
    end else begin
      scan_tck    <= scan_en_w && s_tck;
      scan_tms    <= scan_en_w && s_tms;
      scan_tdi    <= scan_en_w && s_tdi;
      scan_trst_n <= scan_en_w && (!HAS_TRST || s_trst_n);
    end
  end

  // two-wire clock and data from the owning pair
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      swd_clk    <= 1'h0;
      swd_dio_in <= 1'h0;
    end else begin
      swd_clk    <= (swd_scan_w && s_tck) || (swd_usb_w && s_usb_dm);
      swd_dio_in <= (swd_scan_w && s_tms) || (swd_usb_w && s_usb_dp);
    end
  end

  // pin drivers; data-out carries trace or scan data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tms_out    <= 1'h0;
      tms_oe     <= 1'h0;
      usb_dp_out <= 1'h0;
      usb_dp_oe  <= 1'h0;
      tdo_out    <= 1'h0;
      tdo_oe     <= 1'h0;
    end else begin
      tms_out    <= swd_dio_out;
      tms_oe     <= swd_scan_w && swd_dio_oe;
      usb_dp_out <= swd_dio_out;
      usb_dp_oe  <= swd_usb_w && swd_dio_oe;
      tdo_out    <= trace_w ? trace_bit : scan_tdo;
      tdo_oe     <= scan_en_w || trace_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_lock_all_off: assert property (
    state == st_locked |=> !scan_en && !swd_en && pins_claimed == 3'h0
                           && !dbg_circuit_en)
    else $error("port enabled while locked");

  a_pair_single: assert property (
    swd_on_usb |-> swd_en && usb_io_pins_claimed && !tms_oe)
    else $error("two-wire port on both pairs");

  a_window_end: assert property (
    win_open && win_last && !hit_scan && !hit_usb |=>
      state == st_idle [*8])
    else $error("window timeout did not idle");

  a_window_bound: assert property (
    win_open |-> win_cnt < `DPS_WIN_W'(`DPS_KEY_WINDOW_CYC))
    else $error("key window overran");

  a_debug_cause: assert property (
    $rose(on_chip_debug) |-> $past(fw_debug_set) && !$past(dbg_blocked))
    else $error("debug enabled without firmware");

  a_blocked_hold: assert property (
    dbg_blocked && !on_chip_debug |=> !on_chip_debug)
    else $error("blocked debug came back");

  a_trace_only_swd: assert property (
    trace_en |-> swd_en && !scan_en && tdo_oe && pins_claimed == 3'h3)
    else $error("trace outside two-wire mode");

  a_scan_pins: assert property (
    scan_en && !swd_en |-> pins_claimed == (HAS_TRST ? 3'h5 : 3'h4))
    else $error("scan pin count wrong");

  a_swd_no_chain: assert property (
    swd_en && !swd_on_usb |-> !chain_access_en && !scan_en)
    else $error("chain access on two-wire pins");

  a_scan_default: assert property (
    win_open && !s_scan_dis && !s_lock ##1 win_open |-> scan_en)
    else $error("scan port not on by default");

  c_acquire_scan: cover property (win_open ##1 state == st_swd_scan);
  c_acquire_usb:  cover property (win_open ##1 state == st_swd_usb);
  c_timeout:      cover property (win_open ##1 state == st_idle);
  c_locked:       cover property (state == st_locked);

endmodule // dps_port_select

/* File: verif/dps_host_probe.sv */
// host probe model that clocks a key sequence onto one debug pin pair
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module dps_host_probe #(
  parameter int HALF_NS = 400,
  parameter int NBITS   = 8
) (
  input  wire logic        go,
  input  wire logic [15:0] key,
  output logic             lclk,
  output logic             ldat
);
  // link clock stands still low between frames
  initial begin
    lclk = 1'h0;
    ldat = 1'h0;
  end

  // one frame, msb first; data changes only while the clock is low
  // 800 ns period; the short key fits inside the post-reset window
  // edges kept off the system clock edges by a small offset
  always @(posedge go) begin
    #10;
    for (int i = NBITS - 1; i >= 0; i--) begin
      ldat = key[i];
      #HALF_NS lclk = 1'h1;
      #HALF_NS lclk = 1'h0;
    end
    // line released: show the inverse of the last bit, not a held value
    ldat = ~ldat;
  end
endmodule // dps_host_probe

/* File: verif/debug_port_select_and_enable_tb.sv */
// self-checking bench for the debug port select and enable block
`timescale 1ns/1ps
`include "dps_cfg.svh"

////////////////////////////////////////////////////////////////////////////
module debug_port_select_and_enable_tb;
  import dps_pkg::*;

  localparam int LIMIT = 4000; // cycle ceiling, runs need about 2000

  logic sys_clk, arst_n, security_lock, trace_req, trace_bit, scan_tdo;
  logic cfg_scan_disable, cfg_swd_via_scan, cfg_swd_disable, tdi_in;
  logic fw_debug_set, fw_boot_done, chip_erase_done, flash_prot_clear;
  logic swd_scan_reenable, swd_dio_out, swd_dio_oe, trst_n_in, s_go, u_go;
  logic tms_out, tms_oe, tdo_out, tdo_oe, usb_dp_out, usb_dp_oe, scan_en;
  logic scan_tck, scan_tms, scan_tdi, scan_trst_n, chain_access_en, swd_en;
  logic swd_on_usb, swd_clk, swd_dio_in, trace_en, on_chip_debug;
  logic dbg_circuit_en, dbg_blocked, usb_io_pins_claimed;
  logic [2:0]  pins_claimed;
  logic [15:0] k_val;
  wire         s_clk, s_dat, u_clk, u_dat, tms_in, usb_dp_in;
  int          n_errors, n_compared, cyc;

  // pin level worked out from who drives it
  assign tms_in    = tms_oe ? tms_out : s_dat;
  assign usb_dp_in = usb_dp_oe ? usb_dp_out : u_dat;

  dps_host_probe #(.NBITS(`DPS_KEY_LEN)) i_dps_host_probe_scan (.go(s_go),
    .key(k_val), .lclk(s_clk), .ldat(s_dat));
  dps_host_probe #(.NBITS(`DPS_KEY_LEN)) i_dps_host_probe_usb (.go(u_go),
    .key(k_val), .lclk(u_clk), .ldat(u_dat));

  dps_port_select #(.HAS_TRST(1'h1)) i_dps_port_select (
    .sys_clk(sys_clk), .arst_n(arst_n), .security_lock(security_lock),
    .cfg_scan_disable(cfg_scan_disable), .cfg_swd_via_scan(cfg_swd_via_scan),
    .cfg_swd_disable(cfg_swd_disable), .fw_debug_set(fw_debug_set),
    .fw_boot_done(fw_boot_done), .chip_erase_done(chip_erase_done),
    .flash_prot_clear(flash_prot_clear), .swd_scan_reenable(swd_scan_reenable),
    .trace_req(trace_req), .trace_bit(trace_bit), .scan_tdo(scan_tdo),
    .swd_dio_out(swd_dio_out), .swd_dio_oe(swd_dio_oe), .tck_in(s_clk),
    .tms_in(tms_in), .tdi_in(tdi_in), .trst_n_in(trst_n_in),
    .usb_dp_in(usb_dp_in), .usb_dm_in(u_clk), .tms_out(tms_out),
    .tms_oe(tms_oe), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .usb_dp_out(usb_dp_out), .usb_dp_oe(usb_dp_oe), .scan_en(scan_en),
    .scan_tck(scan_tck), .scan_tms(scan_tms), .scan_tdi(scan_tdi),
    .scan_trst_n(scan_trst_n), .chain_access_en(chain_access_en),
    .swd_en(swd_en), .swd_on_usb(swd_on_usb), .swd_clk(swd_clk),
    .swd_dio_in(swd_dio_in), .trace_en(trace_en),
    .on_chip_debug(on_chip_debug), .dbg_circuit_en(dbg_circuit_en),
    .dbg_blocked(dbg_blocked), .usb_io_pins_claimed(usb_io_pins_claimed),
    .pins_claimed(pins_claimed));

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock and hang guard
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task settle();
    @(negedge sys_clk);
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // reset, then optionally send the key on either pair at cycle at
  task boot(input logic lock, input logic [2:0] cfg, input logic sk,
            input logic uk, input int at, input int tot);
    wait_cyc(1);
    {cfg_scan_disable, cfg_swd_via_scan, cfg_swd_disable} <= cfg;
    security_lock    <= lock;
    trace_req        <= 1'h0;
    flash_prot_clear <= 1'h0;
    arst_n           <= 1'h0;
    wait_cyc(20);
    arst_n <= 1'h1;
    wait_cyc(2);
    settle();
    chk(scan_en, 1'h0);
    chk(on_chip_debug, 1'h0);
    wait_cyc(at - 2);
    s_go <= sk;
    u_go <= uk;
    wait_cyc(1);
    s_go <= 1'h0;
    u_go <= 1'h0;
    wait_cyc(tot - at - 1);
    settle();
  endtask

  // one-cycle strobes: debug set, boot done, erase done, scan reenable
  task strobe(input logic [3:0] v);
    wait_cyc(1);
    {fw_debug_set, fw_boot_done, chip_erase_done, swd_scan_reenable} <= v;
    wait_cyc(1);
    {fw_debug_set, fw_boot_done, chip_erase_done, swd_scan_reenable} <= 4'h0;
    wait_cyc(4);
    settle();
  endtask

  task end_test(input string s);
    $display("test %s finished", s);
  endtask

  task tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_clk = 1'h0;
    arst_n = 1'h0;
    {security_lock, cfg_scan_disable, cfg_swd_via_scan} = 3'h0;
    {cfg_swd_disable, fw_debug_set, fw_boot_done, chip_erase_done} = 4'h0;
    {flash_prot_clear, swd_scan_reenable, trace_req, trace_bit} = 4'h0;
    {swd_dio_out, swd_dio_oe, s_go, u_go} = 4'h0;
    {scan_tdo, tdi_in, trst_n_in} = 3'h7;
    k_val = `DPS_SWD_KEY;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    boot(1'h0, 3'h0, 1'h0, 1'h0, 4, 110);
    chk(scan_en, 1'h1);
    chk(chain_access_en, 1'h1);
    chk(pins_claimed, 3'h5);
    chk(swd_en, 1'h0);
    chk(dbg_circuit_en, 1'h0);
    chk({scan_tdi, scan_trst_n, tdo_oe, tdo_out}, 4'hF);
    chk({scan_tck, scan_tms, swd_clk, swd_dio_in, tms_oe}, 5'h0);
    end_test("default");
    boot(1'h0, 3'h4, 1'h0, 1'h0, 4, 110);
    chk({scan_en, scan_tdi, pins_claimed}, 5'h0);
    end_test("scan_off");
    boot(1'h0, 3'h0, 1'h1, 1'h0, 4, 110);
    chk({swd_en, swd_on_usb, pins_claimed}, 5'h12);
    chk({scan_en, chain_access_en}, 2'h0);
    wait_cyc(1);
    {trace_req, trace_bit, scan_tdo} <= 3'h6;
    wait_cyc(5);
    settle();
    chk({trace_en, tdo_out, pins_claimed}, 5'h1B);
    strobe(4'h1);
    chk(scan_en, 1'h1);
    end_test("scan_key");
    boot(1'h0, 3'h0, 1'h0, 1'h1, 4, 110);
    chk({swd_en, swd_on_usb, usb_io_pins_claimed}, 3'h7);
    wait_cyc(1);
    swd_dio_oe <= 1'h1;
    wait_cyc(2);
    settle();
    chk({usb_dp_oe, tms_oe}, 2'h2);
    wait_cyc(1);
    swd_dio_oe <= 1'h0;
    end_test("usb_key");
    boot(1'h0, 3'h0, 1'h1, 1'h1, 4, 110);
    chk({swd_en, swd_on_usb, usb_io_pins_claimed}, 3'h4);
    end_test("both_pairs");
    k_val = ~`DPS_SWD_KEY;
    boot(1'h0, 3'h0, 1'h1, 1'h0, 4, 110);
    chk({swd_en, scan_en}, 2'h1);
    k_val = `DPS_SWD_KEY;
    end_test("wrong_key");
    boot(1'h0, 3'h0, 1'h1, 1'h1, 90, 170);
    chk({swd_en, usb_io_pins_claimed, scan_en}, 3'h1);
    end_test("late_key");
    boot(1'h0, 3'h2, 1'h0, 1'h0, 4, 110);
    chk({swd_en, swd_on_usb, pins_claimed}, 5'h12);
    boot(1'h0, 3'h3, 1'h0, 1'h0, 4, 110);
    chk(swd_en, 1'h0);
    end_test("swd_config");
    boot(1'h0, 3'h5, 1'h1, 1'h0, 4, 110);
    chk(swd_en, 1'h1);
    strobe(4'h1);
    chk(scan_en, 1'h1);
    end_test("reacquire");
    boot(1'h0, 3'h0, 1'h0, 1'h0, 4, 110);
    strobe(4'h8);
    chk({on_chip_debug, dbg_circuit_en}, 2'h3);
    boot(1'h0, 3'h0, 1'h0, 1'h0, 4, 110);
    strobe(4'h4);
    chk(dbg_blocked, 1'h1);
    strobe(4'h8);
    chk(on_chip_debug, 1'h0);
    strobe(4'h2);
    chk(dbg_blocked, 1'h1);
    wait_cyc(1);
    flash_prot_clear <= 1'h1;
    strobe(4'h2);
    chk(dbg_blocked, 1'h0);
    strobe(4'h8);
    chk(on_chip_debug, 1'h1);
    end_test("firmware_debug");
    boot(1'h1, 3'h0, 1'h1, 1'h0, 4, 110);
    chk({swd_en, scan_en, chain_access_en, pins_claimed}, 6'h0);
    strobe(4'h8);
    chk(dbg_circuit_en, 1'h0);
    wait_cyc(1);
    security_lock <= 1'h0;
    wait_cyc(6);
    settle();
    chk(scan_en, 1'h0);
    end_test("security_lock");
    tally_and_finish();
  end
endmodule // debug_port_select_and_enable_tb
